// [arb_clock_divider.sv]
`timescale 1ns/1ps
// Divides the system clock by the programmed count plus one.
module arb_clock_divider
  import scsi_mode_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [DIV_W-1:0] div_count,
  output logic arb_clk
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic level;
  } div_state_t;
  div_state_t st;
  div_state_t next_st;

  // ************************************************************
  // Counter.
  // ************************************************************
  // High for the first half of each period; an even count gives an odd
  // period, so the halves then differ by one cycle.
  always_comb begin
    next_st = st;
    if (st.cnt >= div_count) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
    next_st.level = (next_st.cnt < ((div_count >> 1) + 1'b1));
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign arb_clk = st.level;
endmodule

// [host_dma_model.sv]
`timescale 1ns/1ps
// ************************************************************
// DMA controller on the host side.
// ************************************************************
module host_dma_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [3:0] ack_delay,
  input wire logic dma_req,
  output logic dma_ack
);
  logic [3:0] wait_cnt;
  logic [1:0] hold_cnt;
  // Answers a request after ack_delay cycles and holds acknowledge three cycles.
  // The long hold gives an overlapped request room to show while acknowledge stands.
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dma_ack <= 1'b0;
      wait_cnt <= 4'h0;
      hold_cnt <= 2'h0;
    end else if (dma_ack) begin
      hold_cnt <= hold_cnt + 2'h1;
      if (hold_cnt == 2'h2) begin
        dma_ack <= 1'b0;
      end
    end else if (dma_req) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= ack_delay) begin
        dma_ack <= 1'b1;
        wait_cnt <= 4'h0;
        hold_cnt <= 2'h0;
      end
    end else begin
      wait_cnt <= 4'h0;
    end
  end
endmodule

// [ping_pong_stage.sv]
`timescale 1ns/1ps
// Two alternating staging slots between a bus and the FIFO.
module ping_pong_stage #(
  parameter int W = 9
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready,
  output logic [1:0] occupancy
);
  typedef struct packed {
    logic [1:0][W-1:0] slot;
    logic [1:0] full;
    logic wr_sel;
    logic rd_sel;
  } pp_state_t;
  pp_state_t st;
  pp_state_t next_st;

  // ************************************************************
  // Slot control.
  // ************************************************************
  // Filling alternates between A and B so one slot can drain while the
  // other fills; a clear empties both at once.
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.full = '0;
      next_st.wr_sel = 1'b0;
      next_st.rd_sel = 1'b0;
    end else begin
      if (out_valid && out_ready) begin
        next_st.full[st.rd_sel] = 1'b0;
        next_st.rd_sel = ~st.rd_sel;
      end
      if (in_valid && in_ready) begin
        next_st.slot[st.wr_sel] = in_data;
        next_st.full[st.wr_sel] = 1'b1;
        next_st.wr_sel = ~st.wr_sel;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign in_ready = ~st.full[st.wr_sel];
  assign out_valid = st.full[st.rd_sel];
  assign out_data = st.slot[st.rd_sel];
  assign occupancy = st.full;
endmodule

// [scsi_mode_buffer_clock_regs.sv]
// Operation
// - SCSI parity enable checks SCSI and FIFO output bytes, sets parity flag.
// - Parity error with halt set ends command, sets status 0-2 and extended 7.
// - Target data: bad byte accepted, command ends after current cycle.
// - Initiator data: bad byte not acknowledged, command ends after current cycle.
// - Target script transfer: bad byte received but not written to script memory.
// - Initiator script transfer: bad byte left unreceived for attention.
// - Without overlap, next DMA request waits for acknowledge release.
// - FIFO-ready pin floats unless enabled, then shows buffer can take data.
// - FIFO cleared before data commands unless suppressed; software clears then.
// - Host pins enabled: I/O ready pulled low while FIFO access not ready.
// - Host pins enabled: wide-access pin asserted on 16-bit FIFO access.
// - Parity bit travels unchanged with its data byte.
// - Memory parity check uses input line four as parity bit.
// - Buffer status read shows processor, memory B/A, SCSI B/A occupancy.
// - Memory and SCSI sides use two alternating buffers, processor one.
// - Clock register low nibble is periods minus one for arbitration clock.
// - Input status bit 7 shows live bus reset; latched copy in status bit 6.
// - Input status bit 6 set when attached to differential interface.
// - Input status bit 5 shows buffer-input pin, tied to output when single-ended.
// - Input status bits 4-0 show the five input port lines.
// - Memory parity check bit checks all bytes from the memory bus.
`timescale 1ns/1ps
module scsi_mode_buffer_clock_regs
  import scsi_mode_pkg::*;
#(
  parameter int DIV_W = 4
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [4:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  input wire logic target_mode,
  input wire logic script_xfer,
  input wire logic xfer_start,
  input wire logic fifo_clear_command,
  input wire logic cycle_busy,
  input wire logic scsi_valid,
  input wire logic [7:0] scsi_data,
  input wire logic scsi_par,
  output logic scsi_ack,
  output logic script_memory_wr,
  output logic [7:0] script_memory_data,
  input wire logic mem_valid,
  input wire logic [7:0] mem_data,
  output logic mem_ready,
  output logic scsi_side_valid,
  output logic [8:0] scsi_side_data,
  input wire logic scsi_side_ready,
  output logic mem_side_valid,
  output logic [8:0] mem_side_data,
  input wire logic mem_side_ready,
  input wire logic dma_want,
  input wire logic dma_ack,
  output logic dma_req,
  input wire logic proc_fifo_wr,
  input wire logic proc_fifo_drain,
  input wire logic proc_fifo_access,
  input wire logic proc_wide,
  output logic fifo_rdy_out,
  output logic fifo_rdy_oe,
  output logic io_ready_out,
  output logic io_ready_oe,
  output logic wide_host_access_out,
  output logic wide_host_access_oe,
  output logic fifo_clear,
  output logic cmd_terminate,
  output logic arb_clk,
  input wire logic scsi_rst_in,
  input wire logic diff_scsi_in,
  input wire logic buf_in_pin,
  input wire logic buf_out_level,
  input wire logic [4:0] in_port
);
  typedef struct packed {
    logic [7:0] mode;
    logic [DIV_W-1:0] div;
    logic halt_en;
    logic [7:0] int_stat;
    logic ext_halt;
    logic [7:0] rd_data;
    logic halt_pend;
    logic terminate;
    logic scsi_ack;
    logic script_wr;
    logic [7:0] script_data;
    logic dma_req;
    logic fifo_clear;
    logic proc_full;
    logic fifo_rdy;
    logic io_rdy_oe;
    logic wide_oe;
  } state_t;
  state_t st;
  state_t next_st;

  logic scsi_in_ready;
  logic [1:0] scsi_occ;
  logic [1:0] mem_occ;
  logic scsi_push;
  logic mem_par;
  logic scsi_bad;
  logic mem_bad;
  logic out_bad;
  logic any_bad;
  logic halting_bad;
  logic take_byte;
  logic [7:0] buf_status;
  logic [7:0] in_status;
  logic [7:0] read_mux;

  // ************************************************************
  // Staging buffers and arbitration clock.
  // ************************************************************
  ping_pong_stage #(.W(9)) u_scsi_stage (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(st.fifo_clear),
    .in_valid(scsi_push),
    .in_data({scsi_par, scsi_data}),
    .in_ready(scsi_in_ready),
    .out_valid(scsi_side_valid),
    .out_data(scsi_side_data),
    .out_ready(scsi_side_ready),
    .occupancy(scsi_occ)
  );

  ping_pong_stage #(.W(9)) u_mem_stage (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(st.fifo_clear),
    .in_valid(mem_valid),
    .in_data({mem_par, mem_data}),
    .in_ready(mem_ready),
    .out_valid(mem_side_valid),
    .out_data(mem_side_data),
    .out_ready(mem_side_ready),
    .occupancy(mem_occ)
  );

  arb_clock_divider #(.DIV_W(DIV_W)) u_arb_div (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .div_count(st.div),
    .arb_clk(arb_clk)
  );

  // ************************************************************
  // Parity checks and byte acceptance.
  // ************************************************************
  // Without memory parity checking the parity is generated here, so the
  // stage always carries a valid bit.
  assign mem_par = st.mode[MODE_MEM_PAR] ? in_port[IN_PAR_LINE] : ~^mem_data;
  assign scsi_bad = st.mode[MODE_SCSI_PAR] && scsi_valid
                    && ((^{scsi_par, scsi_data}) != PARITY_GOOD);
  assign mem_bad = st.mode[MODE_MEM_PAR] && mem_valid && mem_ready
                   && ((^{mem_par, mem_data}) != PARITY_GOOD);
  assign out_bad = st.mode[MODE_SCSI_PAR]
                   && ((scsi_side_valid && scsi_side_ready
                        && (^scsi_side_data != PARITY_GOOD))
                       || (mem_side_valid && mem_side_ready
                        && (^mem_side_data != PARITY_GOOD)));
  assign any_bad = scsi_bad || mem_bad || out_bad;
  assign halting_bad = scsi_bad && st.halt_en;
  // Bytes are refused while a halt waits, so nothing slips in after it.
  assign take_byte = scsi_valid && !st.halt_pend
                     && !(halting_bad && !target_mode)
                     && (script_xfer || scsi_in_ready);
  assign scsi_push = take_byte && !script_xfer;

  // ************************************************************
  // Readback.
  // ************************************************************
  assign buf_status = {3'b000, st.proc_full, mem_occ, scsi_occ};
  assign in_status = {scsi_rst_in, diff_scsi_in,
                      (diff_scsi_in ? buf_in_pin : buf_out_level),
                      in_port};

  always_comb begin
    read_mux = READ_ZERO;
    case (addr)
      INT_STATUS_ADDR: read_mux = st.int_stat;
      MODE_BUF_ADDR: read_mux = buf_status;
      CLK_INPUT_ADDR: read_mux = in_status;
      EXT_STATUS_ADDR: read_mux = {st.ext_halt, 7'h00};
      HALT_CTRL_ADDR: read_mux = {7'h00, st.halt_en};
      default: read_mux = READ_ZERO;
    endcase
  end

  // ************************************************************
  // Next state.
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.rd_data = rd_en ? read_mux : READ_ZERO;
    next_st.terminate = 1'b0;
    next_st.scsi_ack = 1'b0;
    next_st.script_wr = 1'b0;
    // Writes.
    if (wr_en) begin
      case (addr)
        MODE_BUF_ADDR: next_st.mode = wr_data;
        CLK_INPUT_ADDR: next_st.div = wr_data[DIV_W-1:0];
        HALT_CTRL_ADDR: next_st.halt_en = wr_data[HALT_BIT];
        default: next_st.halt_en = st.halt_en;
      endcase
    end
    // Status is cleared by reading it; a new event in that cycle wins.
    if (rd_en && addr == INT_STATUS_ADDR) begin
      next_st.int_stat = READ_ZERO;
    end
    if (rd_en && addr == EXT_STATUS_ADDR) begin
      next_st.ext_halt = 1'b0;
    end
    if (any_bad) begin
      next_st.int_stat[INT_PARITY] = 1'b1;
    end
    if (scsi_rst_in) begin
      next_st.int_stat[INT_RESET] = 1'b1;
    end
    // Byte handshake; with halt enabled, a target script byte with bad parity
    // is taken but never reaches the script memory.
    if (take_byte) begin
      next_st.scsi_ack = 1'b1;
      if (script_xfer && !(halting_bad && target_mode)) begin
        next_st.script_wr = 1'b1;
        next_st.script_data = scsi_data;
      end
    end
    // Halt waits for the running memory or processor cycle to end.
    if (halting_bad || (st.halt_en && (mem_bad || out_bad))) begin
      next_st.halt_pend = 1'b1;
    end
    if (st.halt_pend && !cycle_busy) begin
      next_st.halt_pend = 1'b0;
      next_st.terminate = 1'b1;
      next_st.int_stat = next_st.int_stat | HALT_INT_SET;
      next_st.ext_halt = 1'b1;
    end
    // DMA request: dropped on acknowledge, re-raised per overlap mode.
    if (st.dma_req && dma_ack) begin
      next_st.dma_req = 1'b0;
    end else if (!st.dma_req && dma_want
                 && (st.mode[MODE_DMA_OVERLAP] || !dma_ack)) begin
      next_st.dma_req = 1'b1;
    end
    // Automatic clear unless suppressed; the software command always clears.
    next_st.fifo_clear = fifo_clear_command
                         || (xfer_start && !st.mode[MODE_NO_AUTO_CLR]);
    // Single processor buffer.
    if (proc_fifo_drain || st.fifo_clear) begin
      next_st.proc_full = 1'b0;
    end
    if (proc_fifo_wr) begin
      next_st.proc_full = 1'b1;
    end
    next_st.fifo_rdy = !next_st.proc_full;
    // Host pins are open drain: enabled means pulled low.
    next_st.io_rdy_oe = st.mode[MODE_HOST_PINS] && proc_fifo_access
                        && next_st.proc_full;
    next_st.wide_oe = st.mode[MODE_HOST_PINS] && proc_fifo_access
                      && proc_wide;
  end

  // ************************************************************
  // State register.
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign scsi_ack = st.scsi_ack;
  assign script_memory_wr = st.script_wr;
  assign script_memory_data = st.script_data;
  assign dma_req = st.dma_req;
  assign fifo_rdy_out = st.fifo_rdy;
  assign fifo_rdy_oe = st.mode[MODE_FIFO_RDY];
  assign io_ready_out = 1'b0;
  assign io_ready_oe = st.io_rdy_oe;
  assign wide_host_access_out = 1'b0;
  assign wide_host_access_oe = st.wide_oe;
  assign fifo_clear = st.fifo_clear;
  assign cmd_terminate = st.terminate;

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic int_stat_halt;
  logic rd_ext;
  assign int_stat_halt = (st.int_stat[2:0] == HALT_INT_SET[2:0]);
  assign rd_ext = st.ext_halt;

  sequence bad_scsi_byte;
    scsi_bad && st.halt_en && !st.halt_pend;
  endsequence

  sequence halt_done;
    cmd_terminate && int_stat_halt && rd_ext;
  endsequence

  a_parity_flag: assert property (scsi_bad |=> st.int_stat[INT_PARITY])
    else $error("parity error did not set the parity flag");
  a_halt_end: assert property (bad_scsi_byte ##1 !cycle_busy |=> halt_done)
    else $error("halt did not end the command with status");
  a_term_wait: assert property (cmd_terminate |-> !$past(cycle_busy))
    else $error("command ended during a busy cycle");
  a_no_ack_init: assert property ((bad_scsi_byte and !target_mode) |=> !scsi_ack)
    else $error("initiator acknowledged a bad byte");
  a_script_block: assert property ((bad_scsi_byte and (target_mode && script_xfer))
                                   |=> scsi_ack && !script_memory_wr)
    else $error("bad target byte reached script memory");
  a_dma_gap: assert property (dma_ack && !st.mode[MODE_DMA_OVERLAP] && !dma_req
                              |=> !dma_req)
    else $error("request raised under acknowledge");
  a_clear_cmd: assert property (xfer_start && !st.mode[MODE_NO_AUTO_CLR]
                                |=> fifo_clear ##1 !scsi_side_valid)
    else $error("automatic clear missing");
  a_wide_pin: assert property (st.mode[MODE_HOST_PINS] && proc_fifo_access && proc_wide
                               && !(wr_en && addr == MODE_BUF_ADDR)
                               |=> wide_host_access_oe)
    else $error("wide access pin not asserted");
  a_reset_live: assert property (rd_en && addr == CLK_INPUT_ADDR
                                 |=> rd_data[7] == $past(scsi_rst_in))
    else $error("reset status not live");
endmodule

// [scsi_mode_pkg.sv]
package scsi_mode_pkg;
  // ************************************************************
  // Register map.
  // ************************************************************
  localparam logic [4:0] INT_STATUS_ADDR = 5'h05;
  localparam logic [4:0] MODE_BUF_ADDR = 5'h07;
  localparam logic [4:0] CLK_INPUT_ADDR = 5'h08;
  localparam logic [4:0] EXT_STATUS_ADDR = 5'h11;
  localparam logic [4:0] HALT_CTRL_ADDR = 5'h14;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [3:0] DIV_RESET = 4'h0;
  // ************************************************************
  // Field positions.
  // ************************************************************
  localparam int MODE_HOST_PINS = 0;
  localparam int MODE_NO_AUTO_CLR = 1;
  localparam int MODE_FIFO_RDY = 2;
  localparam int MODE_DMA_OVERLAP = 3;
  localparam int MODE_SCSI_PAR = 4;
  localparam int MODE_MEM_PAR = 5;
  localparam int INT_PARITY = 2;
  localparam int INT_RESET = 6;
  localparam int EXT_PARITY_HALT = 7;
  localparam int HALT_BIT = 0;
  localparam int IN_PAR_LINE = 4;
  localparam logic [7:0] HALT_INT_SET = 8'h07;
  // Odd parity: a good byte plus its parity bit has an odd count of ones.
  localparam logic PARITY_GOOD = 1'b1;
  // ************************************************************
  // Timing.
  // ************************************************************
  localparam int ARB_CLK_TARGET_NS = 400;
  localparam int SYS_CLK_PERIOD_NS = 20;
  localparam int ARB_DIV_SUGGESTED = ARB_CLK_TARGET_NS / SYS_CLK_PERIOD_NS - 1;
endpackage

// [testbench.sv]
`timescale 1ns/1ps
module testbench;
  import scsi_mode_pkg::*;
  logic sys_clk, rstn, wr_en, rd_en, target_mode, script_xfer, xfer_start, cycle_busy;
  logic fifo_clear_command, scsi_valid, scsi_par, mem_valid, scsi_side_ready, mem_side_ready;
  logic dma_want, dma_ack, proc_fifo_wr, proc_fifo_drain, proc_fifo_access, proc_wide;
  logic scsi_rst_in, diff_scsi_in, buf_in_pin, buf_out_level, rd_pend, req_prev;
  logic scsi_ack, script_memory_wr, mem_ready, scsi_side_valid, mem_side_valid, dma_req;
  logic fifo_rdy_out, fifo_rdy_oe, io_ready_out, io_ready_oe, wide_host_access_out;
  logic wide_host_access_oe, fifo_clear, cmd_terminate, arb_clk;
  logic [4:0] addr, in_port;
  logic [7:0] wr_data, rd_data, scsi_data, mem_data, script_memory_data, d;
  logic [8:0] scsi_side_data, mem_side_data;
  logic [3:0] ack_delay;
  logic [3:0] divs[3] = '{4'h2, 4'h4, 4'hA};
  logic [31:0] lfsr;
  logic [7:0] exp_q[$];
  int errors, samples_checked, req_rises, rises_under_ack, p, m, k;

  scsi_mode_buffer_clock_regs #(.DIV_W(4)) i_scsi_mode_buffer_clock_regs (
    .sys_clk, .rstn, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .target_mode, .script_xfer,
    .xfer_start, .fifo_clear_command, .cycle_busy, .scsi_valid, .scsi_data, .scsi_par,
    .scsi_ack, .script_memory_wr, .script_memory_data, .mem_valid, .mem_data, .mem_ready,
    .scsi_side_valid, .scsi_side_data, .scsi_side_ready, .mem_side_valid, .mem_side_data,
    .mem_side_ready, .dma_want, .dma_ack, .dma_req, .proc_fifo_wr, .proc_fifo_drain,
    .proc_fifo_access, .proc_wide, .fifo_rdy_out, .fifo_rdy_oe, .io_ready_out, .io_ready_oe,
    .wide_host_access_out, .wide_host_access_oe, .fifo_clear, .cmd_terminate, .arb_clk,
    .scsi_rst_in, .diff_scsi_in, .buf_in_pin, .buf_out_level, .in_port
  );
  host_dma_model i_host_dma_model (.sys_clk, .rstn, .ack_delay, .dma_req, .dma_ack);

  // ************************************************************
  // Clock, helpers and result watchers.
  // ************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Galois-free shift sequence; fixed start keeps every run identical.
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    errors += exp_q.size();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask

  // The expected byte is noted now and compared when the data come back.
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask

  // Registered outputs need two edges after a cause before they are settled.
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic scsi_send(input logic [7:0] v, input logic bad, input logic ack, input logic sw);
    @(posedge sys_clk);
    scsi_valid <= 1'b1;
    scsi_data <= v;
    scsi_par <= ~^v ^ bad;
    @(posedge sys_clk);
    scsi_valid <= 1'b0;
    @(negedge sys_clk);
    check("scsi_ack", 9'(scsi_ack), 9'(ack));
    check("script_wr", 9'(script_memory_wr), 9'(sw));
  endtask

  task automatic mem_send(input logic [7:0] v, input logic par);
    @(posedge sys_clk);
    mem_valid <= 1'b1;
    mem_data <= v;
    in_port[IN_PAR_LINE] <= par;
    @(posedge sys_clk);
    mem_valid <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic clear_try(input logic cmd, input logic exp);
    @(posedge sys_clk);
    xfer_start <= !cmd;
    fifo_clear_command <= cmd;
    @(posedge sys_clk);
    xfer_start <= 1'b0;
    fifo_clear_command <= 1'b0;
    @(negedge sys_clk);
    check("fifo_clear", 9'(fifo_clear), 9'(exp));
  endtask

  task automatic arb_period(output int per);
    logic last;
    int first;
    last = arb_clk;
    first = -1;
    per = 0;
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      if (arb_clk === 1'b1 && last !== 1'b1) begin
        if (first >= 0) begin
          per = i - first;
          break;
        end
        first = i;
      end
      last = arb_clk;
    end
  endtask

  // Read data stand only in the cycle after the strobe, so the oldest note is due then.
  always @(posedge sys_clk) rd_pend <= rd_en;
  always @(negedge sys_clk) begin
    if (rd_pend === 1'b1) begin
      check("rd_data", {1'b0, rd_data}, {1'b0, exp_q.pop_front()});
    end
    if (dma_req === 1'b1 && req_prev !== 1'b1) begin
      req_rises++;
      if (dma_ack === 1'b1) rises_under_ack++;
    end
    req_prev = dma_req;
  end

  // The whole sequence needs well under a thousand cycles; five thousand means a hang.
  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    summarize();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    {rstn, wr_en, rd_en, target_mode, script_xfer, xfer_start, cycle_busy} = '0;
    {fifo_clear_command, scsi_valid, scsi_par, mem_valid, dma_want, proc_fifo_wr} = '0;
    {proc_fifo_drain, proc_fifo_access, proc_wide, scsi_rst_in, diff_scsi_in} = '0;
    {buf_in_pin, buf_out_level, addr, in_port, wr_data, scsi_data, mem_data} = '0;
    {scsi_side_ready, mem_side_ready, ack_delay} = '0;
    lfsr = 32'h000145BA;
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(MODE_BUF_ADDR, 8'h00);
    for (m = 0; m < 3; m++) begin
      lfsr = next_rand(lfsr);
      @(posedge sys_clk);
      {diff_scsi_in, buf_in_pin, buf_out_level, in_port} <= lfsr[7:0];
      scsi_rst_in <= (m == 0);
      d = {m == 0, lfsr[7], lfsr[7] ? lfsr[6] : lfsr[5], lfsr[4:0]};
      rd(CLK_INPUT_ADDR, d);
    end
    rd(INT_STATUS_ADDR, 8'h40);
    rd(5'h1F, 8'h00);
    // Optional pin drives stay off until their mode bits are written.
    @(posedge sys_clk);
    proc_fifo_access <= 1'b1;
    proc_wide <= 1'b1;
    settle();
    check("fifo_rdy_oe", 9'(fifo_rdy_oe), 9'h000);
    check("wide_oe", 9'(wide_host_access_oe), 9'h000);
    wr(MODE_BUF_ADDR, 8'h05);
    settle();
    check("fifo_rdy_oe", 9'(fifo_rdy_oe), 9'h001);
    check("fifo_rdy_out", 9'(fifo_rdy_out), 9'h001);
    check("wide_oe", 9'(wide_host_access_oe), 9'h001);
    check("wide_out", 9'(wide_host_access_out), 9'h000);
    @(posedge sys_clk);
    proc_fifo_wr <= 1'b1;
    @(posedge sys_clk);
    proc_fifo_wr <= 1'b0;
    settle();
    check("fifo_rdy_out", 9'(fifo_rdy_out), 9'h000);
    check("io_ready_oe", 9'(io_ready_oe), 9'h001);
    check("io_ready_out", 9'(io_ready_out), 9'h000);
    rd(MODE_BUF_ADDR, 8'h10);
    @(posedge sys_clk);
    proc_fifo_drain <= 1'b1;
    proc_fifo_access <= 1'b0;
    proc_wide <= 1'b0;
    @(posedge sys_clk);
    proc_fifo_drain <= 1'b0;
    settle();
    check("io_ready_oe", 9'(io_ready_oe), 9'h000);
    check("wide_oe", 9'(wide_host_access_oe), 9'h000);
    clear_try(1'b0, 1'b1);
    wr(MODE_BUF_ADDR, 8'h07);
    clear_try(1'b0, 1'b0);
    clear_try(1'b1, 1'b1);
    // Two slots fill, the third byte is refused while the FIFO side stalls.
    wr(MODE_BUF_ADDR, 8'h10);
    @(posedge sys_clk);
    target_mode <= 1'b1;
    for (m = 0; m < 3; m++) begin
      lfsr = next_rand(lfsr);
      scsi_send(lfsr[7:0], 1'b0, m < 2, 1'b0);
      if (m == 0) check("scsi_word", scsi_side_data, {~^lfsr[7:0], lfsr[7:0]});
      rd(MODE_BUF_ADDR, (m != 0) ? 8'h03 : 8'h01);
    end
    @(posedge sys_clk);
    scsi_side_ready <= 1'b1;
    mem_side_ready <= 1'b1;
    @(posedge sys_clk);
    rd(MODE_BUF_ADDR, 8'h00);
    d = lfsr[15:8];
    scsi_send(d, 1'b1, 1'b1, 1'b0);
    check("scsi_word", scsi_side_data, {^d, d});
    rd(INT_STATUS_ADDR, 8'h04);
    // Halt on each transfer kind; termination waits for the running cycle.
    wr(HALT_CTRL_ADDR, 8'h01);
    for (m = 0; m < 4; m++) begin
      @(posedge sys_clk);
      target_mode <= m[0];
      script_xfer <= m[1];
      cycle_busy <= 1'b1;
      scsi_send(8'h5A, 1'b1, m[0], 1'b0);
      for (k = 0; k < 4; k++) begin
        @(negedge sys_clk);
        check("early_end", 9'(cmd_terminate), 9'h000);
      end
      @(posedge sys_clk);
      cycle_busy <= 1'b0;
      for (k = 0; k < 8; k++) begin
        @(negedge sys_clk);
        if (cmd_terminate === 1'b1) break;
      end
      check("cmd_end", 9'(k < 8), 9'h001);
      rd(INT_STATUS_ADDR, 8'h07);
      rd(EXT_STATUS_ADDR, 8'h80);
    end
    wr(HALT_CTRL_ADDR, 8'h00);
    scsi_send(8'hC3, 1'b0, 1'b1, 1'b1);
    check("script_data", 9'(script_memory_data), 9'h0C3);
    // Memory side: parity rides on input line four when checking is on.
    wr(MODE_BUF_ADDR, 8'h20);
    @(posedge sys_clk);
    script_xfer <= 1'b0;
    mem_side_ready <= 1'b0;
    mem_send(8'h96, 1'b0);
    check("mem_word", mem_side_data, 9'h096);
    rd(MODE_BUF_ADDR, 8'h04);
    rd(INT_STATUS_ADDR, 8'h04);
    wr(MODE_BUF_ADDR, 8'h00);
    @(posedge sys_clk);
    mem_side_ready <= 1'b1;
    repeat (3) @(posedge sys_clk);
    mem_send(8'h17, 1'b0);
    check("mem_word", mem_side_data, 9'h117);
    // Request spacing against the acknowledge, without and with overlap.
    for (m = 0; m < 2; m++) begin
      @(posedge sys_clk);
      ack_delay <= (m != 0) ? 4'h3 : 4'h0;
      dma_want <= 1'b1;
      req_rises = 0;
      rises_under_ack = 0;
      repeat (30) @(posedge sys_clk);
      dma_want <= 1'b0;
      check("dma_rises", 9'(req_rises != 0), 9'h001);
      check("req_under_ack", 9'(rises_under_ack != 0), 9'(m));
      wr(MODE_BUF_ADDR, 8'h08);
    end
    // Even divider counts only, giving odd periods whose halves differ by one cycle.
    for (m = 0; m < 3; m++) begin
      wr(CLK_INPUT_ADDR, {4'h0, divs[m]});
      arb_period(p);
      check("arb_period", 9'(p), 9'(divs[m]) + 9'h001);
    end
    repeat (4) @(posedge sys_clk);
    summarize();
  end
endmodule
